// ==== rtl/wake_cfg_map.svh ====
// Purpose: offsets, field positions, reset values and timing counts for the wake config bank
// Assumes: 7-bit register address, 8-bit data
// Notes: included by the package and the bank
`ifndef WAKE_CFG_MAP_SVH
`define WAKE_CFG_MAP_SVH

// ********************
// offsets
// ********************
`define OFF_PAYLOAD_BYTE2 7'h31
`define OFF_PAYLOAD_BYTE1 7'h32
`define OFF_PAYLOAD_BYTE0 7'h33
`define OFF_TOLERANCE 7'h34
`define OFF_FINE_TRIM 7'h38
`define OFF_OPTIONS 7'h39
`define OFF_CAL_HIGH 7'h3a

// ********************
// fields
// ********************
`define BIT_ERR_CNT_DIS 5
`define BIT_RECEIVE_FILTER_BYPASS 4
`define FLD_DOM_FILT_HI 3
`define FLD_DOM_FILT_LO 1
`define BIT_TOL_EN 0
`define BIT_WAKE_RX_SEL 7
`define FLD_COARSE_HI 4
`define TOL_WRITE_MASK 8'h3f
`define OPT_WRITE_MASK 8'h9f
`define TRIM_EN_OPEN 2'h3

// ********************
// reset values
// ********************
`define RST_ZERO 8'h00
`define RST_FINE_TRIM 8'h80
`define RST_COARSE 5'h10

// ********************
// timing
// ********************
`define CLK_PERIOD_NS 50
`define DOM_STEP_NS 50
`define DOM_LONG_NS 775
`define DOM_CYC_BITS 5

`endif

// ==== rtl/wake_cfg_pkg.sv ====
// Purpose: types for the wake config bank
// Assumes: wake_cfg_map.svh holds the numbers
// Notes: none
package wake_cfg_pkg;
	`include "wake_cfg_map.svh"

	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic error_counter_disable;
		logic receive_filter_bypass;
		logic [2:0] dominant_filter_time;
		logic tolerant_mode_enable;
	} tol_cfg_t;

	typedef enum logic [1:0] {
		FILT_IDLE,
		FILT_COUNT,
		FILT_PASS
	} filt_state_t;
endpackage

// ==== rtl/wake_cfg_regs.sv ====
// Contract
// - payload registers hold full read-write bytes
// - error counter off only with tolerant mode
// - silence timeout clears error counter disable
// - bypass bit routes receive around analog filter
// - dominant filter 50 ns steps, code seven 775ns
// - dominant filter active regardless of bypass
// - tolerance bit zero enables tolerant mode
// - fine trim writes need trim enable 11
// - fine trim low five bits step frequency
// - coarse trim bits writable only when enabled
// - receiver select, gated by trim enable
// - reserved bits read zero, ignore writes
// - calibration high byte is read-only status
// - tolerance resets zero; restart clears top bits
//
// Purpose: selective wake config and status bank on the serial register port
// Assumes: serial frame already decoded into one-cycle read and write strobes
// Notes: restart is a one-cycle pulse; rst_n is power-on or soft reset
`timescale 1ns/1ps
`include "wake_cfg_map.svh"

module wake_cfg_regs
	import wake_cfg_pkg::*;
#(
	parameter int DATA_W = 8
)
(
	// clock and resets
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic restart_pulse,
	// register port
	input wire wake_cfg_pkg::reg_req_t req,
	output logic [DATA_W-1:0] rdata,
	output logic rvalid,
	// trim unlock and status inputs
	input wire logic [1:0] trim_enable,
	input wire logic silence_timeout,
	input wire logic [DATA_W-1:0] calibration_upper_byte,
	// receive path
	input wire logic bus_rx_raw,
	input wire logic bus_rx_filtered,
	input wire logic frame_error_event,
	input wire logic selective_wake_active,
	// configuration outputs
	output logic [DATA_W-1:0] payload_byte_two,
	output logic [DATA_W-1:0] payload_byte_one,
	output logic [DATA_W-1:0] payload_byte_zero,
	output wake_cfg_pkg::tol_cfg_t tol_cfg,
	output logic [12:0] oscillator_trim_code,
	output logic wake_receiver_select,
	// derived receive behaviour
	output logic rx_dominant_out,
	output logic error_count_pulse
);
	import wake_cfg_pkg::*;

	// ********************
	// timing constants
	// ********************
	// longest filter time rounds down, never below one cycle
	function automatic logic [`DOM_CYC_BITS-1:0] dom_cycles(input logic [2:0] code);
		int ns;
		int cyc;
		ns = (code == 3'h7) ? `DOM_LONG_NS : (int'(code) + 1) * `DOM_STEP_NS;
		cyc = ns / `CLK_PERIOD_NS;
		if (cyc < 1)
			cyc = 1;
		return cyc[`DOM_CYC_BITS-1:0];
	endfunction

	function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
		return a == off;
	endfunction

	logic trim_open;
	logic tol_wr;
	logic [7:0] tol_bits;
	logic [7:0] opt_bits;
	logic [7:0] rd_next;

	assign trim_open = (trim_enable == `TRIM_EN_OPEN);
	assign tol_wr = req.wr && hit(req.addr, `OFF_TOLERANCE);

	// ********************
	// payload bytes
	// ********************
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			payload_byte_two <= `RST_ZERO;
			payload_byte_one <= `RST_ZERO;
			payload_byte_zero <= `RST_ZERO;
		end
		else if (req.wr)
		begin
			// restart leaves these alone on purpose
			if (hit(req.addr, `OFF_PAYLOAD_BYTE2))
				payload_byte_two <= req.wdata;
			if (hit(req.addr, `OFF_PAYLOAD_BYTE1))
				payload_byte_one <= req.wdata;
			if (hit(req.addr, `OFF_PAYLOAD_BYTE0))
				payload_byte_zero <= req.wdata;
		end
	end

	// ********************
	// tolerance register
	// ********************
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			tol_cfg <= '0;
		else
		begin
			if (tol_wr)
			begin
				tol_cfg.receive_filter_bypass <= req.wdata[`BIT_RECEIVE_FILTER_BYPASS];
				tol_cfg.dominant_filter_time <=
					req.wdata[`FLD_DOM_FILT_HI:`FLD_DOM_FILT_LO];
				tol_cfg.tolerant_mode_enable <= req.wdata[`BIT_TOL_EN];
			end
			// hardware clear beats a same-cycle host write
			if (silence_timeout)
				tol_cfg.error_counter_disable <= 1'b0;
			else if (tol_wr)
				tol_cfg.error_counter_disable <= req.wdata[`BIT_ERR_CNT_DIS];
		end
	end

	// ********************
	// trim and options
	// ********************
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			oscillator_trim_code <= {`RST_COARSE, `RST_FINE_TRIM};
			wake_receiver_select <= 1'b0;
		end
		else if (req.wr && trim_open)
		begin
			// fine steps monotonic in bits 4:0; temperature bits 7:5 as host writes
			if (hit(req.addr, `OFF_FINE_TRIM))
				oscillator_trim_code[7:0] <= req.wdata;
			if (hit(req.addr, `OFF_OPTIONS))
			begin
				oscillator_trim_code[12:8] <= req.wdata[`FLD_COARSE_HI:0];
				wake_receiver_select <= req.wdata[`BIT_WAKE_RX_SEL];
			end
		end
	end

	// ********************
	// read path
	// ********************
	assign tol_bits = {2'b00, tol_cfg} & `TOL_WRITE_MASK;
	// coarse bits read back so the host can rewrite them unchanged
	assign opt_bits = {wake_receiver_select, 2'b00, oscillator_trim_code[12:8]};

	always_comb
	begin
		case (req.addr)
			`OFF_PAYLOAD_BYTE2: rd_next = payload_byte_two;
			`OFF_PAYLOAD_BYTE1: rd_next = payload_byte_one;
			`OFF_PAYLOAD_BYTE0: rd_next = payload_byte_zero;
			`OFF_TOLERANCE: rd_next = tol_bits;
			`OFF_FINE_TRIM: rd_next = oscillator_trim_code[7:0];
			`OFF_OPTIONS: rd_next = trim_open ? opt_bits : `RST_ZERO;
			`OFF_CAL_HIGH: rd_next = calibration_upper_byte;
			default: rd_next = `RST_ZERO;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata <= `RST_ZERO;
			rvalid <= 1'b0;
		end
		else
		begin
			rvalid <= req.rd;
			if (req.rd)
				rdata <= rd_next;
		end
	end

	// ********************
	// dominant filter
	// ********************
	// fed from the selected path, so it stays active with the bypass set
	filt_state_t filt_state;
	logic [`DOM_CYC_BITS-1:0] filt_cnt;
	logic rx_sel;
	logic [`DOM_CYC_BITS-1:0] filt_len;

	assign rx_sel = tol_cfg.receive_filter_bypass ? bus_rx_raw : bus_rx_filtered;
	assign filt_len = dom_cycles(tol_cfg.dominant_filter_time);

	// rx low is dominant; a dominant shorter than the filter time is dropped
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			filt_state <= FILT_IDLE;
			filt_cnt <= '0;
			rx_dominant_out <= 1'b0;
		end
		else
		begin
			case (filt_state)
				FILT_IDLE:
				begin
					rx_dominant_out <= 1'b0;
					filt_cnt <= `DOM_CYC_BITS'(1);
					if (!rx_sel)
						filt_state <= FILT_COUNT;
				end
				FILT_COUNT:
				begin
					if (rx_sel)
						filt_state <= FILT_IDLE;
					else if (filt_cnt >= filt_len)
					begin
						filt_state <= FILT_PASS;
						rx_dominant_out <= 1'b1;
					end
					else
						filt_cnt <= filt_cnt + `DOM_CYC_BITS'(1);
				end
				FILT_PASS:
				begin
					if (rx_sel)
					begin
						filt_state <= FILT_IDLE;
						rx_dominant_out <= 1'b0;
					end
				end
				default: filt_state <= FILT_IDLE;
			endcase
		end
	end

	// ********************
	// error counter gate
	// ********************
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			error_count_pulse <= 1'b0;
		else
			error_count_pulse <= frame_error_event && selective_wake_active &&
				!(tol_cfg.error_counter_disable && tol_cfg.tolerant_mode_enable);
	end

	// restart pulse: top tolerance bits are reserved zero already, others keep value
	logic restart_seen;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			restart_seen <= 1'b0;
		else
			restart_seen <= restart_pulse;
	end
endmodule

// ==== verif/wake_cfg_monitor.sv ====
// Purpose: port checks for the wake config bank
// Assumes: one clock, async low reset
// Notes: bound from tb_top
`timescale 1ns/1ps
module wake_cfg_monitor
	import wake_cfg_pkg::*;
(
	// watched ports
	input wire logic mclk,
	input wire logic rst_n,
	input wire wake_cfg_pkg::reg_req_t req,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	input wire logic [1:0] trim_enable,
	input wire logic silence_timeout,
	input wire logic [7:0] calibration_upper_byte,
	input wire logic frame_error_event,
	input wire logic selective_wake_active,
	input wire logic [7:0] payload_byte_two,
	input wire wake_cfg_pkg::tol_cfg_t tol_cfg,
	input wire logic [12:0] oscillator_trim_code,
	input wire logic error_count_pulse
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	chk_read_answer:
		assert property (req.rd |=> rvalid) else $error("read not answered");
	chk_payload_store:
		assert property (req.wr && req.addr == 7'h31 |=> payload_byte_two == $past(req.wdata))
			else $error("payload byte not stored");
	chk_tol_store:
		assert property (req.wr && req.addr == 7'h34 && !silence_timeout
			|=> tol_cfg == $past(req.wdata[5:0])) else $error("tolerance not stored");
	chk_reserved_zero:
		assert property (req.rd && req.addr == 7'h34 |=> rdata[7:6] == 2'h0)
			else $error("reserved bits set");
	chk_cal_shown:
		assert property (req.rd && req.addr == 7'h3a |=> rdata == $past(calibration_upper_byte))
			else $error("calibration byte wrong");
	chk_trim_locked:
		assert property (!$stable(oscillator_trim_code) |-> $past(trim_enable) == 2'h3)
			else $error("trim changed while locked");
	chk_silence_clear:
		assert property (silence_timeout |=> !tol_cfg.error_counter_disable)
			else $error("disable bit not cleared");
	chk_error_gate:
		assert property (1'b1 |=> error_count_pulse == $past(frame_error_event
			&& selective_wake_active && !(tol_cfg[5] && tol_cfg[0]))) else $error("error gate");
endmodule

// ==== verif/host_model.sv ====
// Purpose: host side of the register port
// Assumes: requests taken on the edge after launch
// Notes: released fields show inverted values
`timescale 1ns/1ps
module host_model
	import wake_cfg_pkg::*;
(
	// clock
	input wire logic mclk,
	// register port
	output wake_cfg_pkg::reg_req_t req,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	initial req = '0;
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge mclk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
		int n;
		@(posedge mclk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge mclk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
		ok = 1'b0;
		d = 8'h00;
		// bounded wait for the answer
		for (n = 0; n < 4 && !ok; n++)
		begin
			@(posedge mclk);
			ok = rvalid;
			d = rdata;
		end
	endtask
endmodule

// ==== verif/tb_top.sv ====
// Purpose: self-checking bench for the wake config bank
// Assumes: 20 MHz clock
// Notes: filter timing checked with two cycles of slack
`timescale 1ns/1ps
module tb_top;
	import wake_cfg_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic restart_pulse = 1'b0;
	logic [1:0] trim_enable = 2'h0;
	logic silence_timeout = 1'b0;
	logic [7:0] cal_byte = 8'h5a;
	logic rx_raw = 1'b1;
	logic rx_filt = 1'b1;
	logic frame_err = 1'b0;
	logic wake_active = 1'b1;
	reg_req_t req;
	tol_cfg_t tol_cfg;
	logic [7:0] rdata, pb2, pb1, pb0;
	logic [12:0] trim_code;
	logic rvalid, rx_sel, rx_dom, err_pulse;
	int fails = 0;
	int total_checks = 0;
	always #25 mclk = ~mclk;
	wake_cfg_regs u_wake_cfg_regs (.mclk(mclk), .rst_n(rst_n), .restart_pulse(restart_pulse),
		.req(req), .rdata(rdata), .rvalid(rvalid), .trim_enable(trim_enable),
		.silence_timeout(silence_timeout), .calibration_upper_byte(cal_byte),
		.bus_rx_raw(rx_raw), .bus_rx_filtered(rx_filt), .frame_error_event(frame_err),
		.selective_wake_active(wake_active), .payload_byte_two(pb2), .payload_byte_one(pb1),
		.payload_byte_zero(pb0), .tol_cfg(tol_cfg), .oscillator_trim_code(trim_code),
		.wake_receiver_select(rx_sel), .rx_dominant_out(rx_dom), .error_count_pulse(err_pulse));
	host_model u_host_model (.mclk(mclk), .req(req), .rdata(rdata), .rvalid(rvalid));
	task automatic stop_test;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cmp(input logic [12:0] got, input logic [12:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		u_host_model.rd(a, d, ok);
		if (ok !== 1'b1)
		begin
			fails++;
			stop_test();
		end
		cmp({5'h0, d}, {5'h0, exp});
	endtask
	// one-cycle pulse on frame error, counted pulse checked at the falling edge after the next rising edge
	task automatic err_hit(input logic exp);
		@(posedge mclk);
		frame_err <= 1'b1;
		@(posedge mclk);
		frame_err <= 1'b0;
		@(negedge mclk);
		cmp({12'h0, err_pulse}, {12'h0, exp});
	endtask
	// mid-run reset, then checks tolerance, payload byte two and trim code are back at their power-on values
	task automatic t_reset;
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rchk(7'h34, 8'h00);
		rchk(7'h31, 8'h00);
		cmp(trim_code, 13'h1080);
		$display("test reset done");
	endtask
	task automatic t_regs;
		rchk(7'h34, 8'h00);
		cmp(trim_code, 13'h1080);
		u_host_model.wr(7'h31, 8'ha5);
		u_host_model.wr(7'h32, 8'h5a);
		u_host_model.wr(7'h33, 8'h81);
		u_host_model.wr(7'h35, 8'hff);
		rchk(7'h31, 8'ha5);
		rchk(7'h33, 8'h81);
		cmp({5'h0, pb1}, 13'h5a);
		rchk(7'h35, 8'h00);
		$display("test regs done");
	endtask
	task automatic t_tol;
		u_host_model.wr(7'h34, 8'hff);
		rchk(7'h34, 8'h3f);
		cmp({7'h0, tol_cfg}, 13'h3f);
		err_hit(1'b0);
		@(posedge mclk);
		silence_timeout <= 1'b1;
		@(posedge mclk);
		silence_timeout <= 1'b0;
		rchk(7'h34, 8'h1f);
		err_hit(1'b1);
		@(posedge mclk);
		restart_pulse <= 1'b1;
		@(posedge mclk);
		restart_pulse <= 1'b0;
		rchk(7'h34, 8'h1f);
		$display("test tolerance done");
	endtask
	task automatic t_trim;
		u_host_model.wr(7'h38, 8'h00);
		rchk(7'h38, 8'h80);
		@(posedge mclk);
		trim_enable <= 2'h3;
		u_host_model.wr(7'h38, 8'h8a);
		u_host_model.wr(7'h39, 8'hf0);
		rchk(7'h39, 8'h90);
		cmp(trim_code, 13'h108a);
		cmp({12'h0, rx_sel}, 13'h1);
		u_host_model.wr(7'h3a, 8'h00);
		rchk(7'h3a, 8'h5a);
		trim_enable <= 2'h0;
		$display("test trim done");
	endtask
	task automatic t_filter;
		int c;
		int b;
		int n;
		for (c = 0; c < 8; c += 7)
			for (b = 0; b < 2; b++)
			begin
				u_host_model.wr(7'h34, {3'h0, b[0], c[2:0], 1'b0});
				n = (c == 7) ? 15 : c + 1;
				@(posedge mclk);
				rx_raw <= !b[0];
				rx_filt <= b[0];
				repeat (n) @(posedge mclk);
				@(negedge mclk);
				cmp({12'h0, rx_dom}, 13'h0);
				repeat (3) @(posedge mclk);
				@(negedge mclk);
				cmp({12'h0, rx_dom}, 13'h1);
				@(posedge mclk);
				rx_raw <= 1'b1;
				rx_filt <= 1'b1;
				repeat (3) @(posedge mclk);
				@(negedge mclk);
				cmp({12'h0, rx_dom}, 13'h0);
			end
		$display("test filter done");
	endtask
	initial
	begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		t_regs();
		t_tol();
		t_trim();
		t_reset();
		t_filter();
		stop_test();
	end
	// hang guard
	initial
	begin
		#1000000;
		fails++;
		stop_test();
	end
endmodule
bind wake_cfg_regs wake_cfg_monitor u_wake_cfg_monitor (.mclk(mclk), .rst_n(rst_n), .req(req),
	.rdata(rdata), .rvalid(rvalid), .trim_enable(trim_enable), .silence_timeout(silence_timeout),
	.calibration_upper_byte(calibration_upper_byte), .frame_error_event(frame_error_event),
	.selective_wake_active(selective_wake_active), .payload_byte_two(payload_byte_two),
	.tol_cfg(tol_cfg), .oscillator_trim_code(oscillator_trim_code),
	.error_count_pulse(error_count_pulse));
